// *** oscmd_chk.sv ***
// Port checker for the output and system command handler
`timescale 1ns/1ps
module oscmd_chk
  import oscmd_pkg::*;
#(
  parameter int DEPTH = ERR_DEPTH, // Queue entries
  parameter int AW = 4 // Pointer width
) (
  input wire logic mclk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB access
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic output_on, // Output enable
  input wire logic iso_relay, // Isolation relay
  input wire logic pol_inverted, // Polarity relay
  input wire logic aux_rail_low_enable, // Low rail
  input wire logic aux_rail_high_enable, // High rail
  input wire logic rear_sense_connector, // Rear sense
  input wire logic local_mode // Local operation
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Accepted write completing at one register
  sequence acc_wr(logic [7:0] a);
    psel && penable && pready && pwrite && ce && paddr == a && !pslverr;
  endsequence
  // Read answer from one register
  sequence acc_rd(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  out_on_wr_a: assert property (acc_wr(REG_OUT_STATE) ##0 pwdata == 32'h1 |=> output_on && iso_relay)
    else $error("output on write not applied");
  out_off_wr_a: assert property (acc_wr(REG_OUT_STATE) ##0 pwdata == 32'h0 |=> !output_on && !iso_relay)
    else $error("output off write not applied");
  out_rd_a: assert property (acc_rd(REG_OUT_STATE) |-> prdata == {31'h0, output_on})
    else $error("output state read wrong");
  rst_cmd_a: assert property (acc_wr(REG_CMD) ##0 (pwdata[31:2] == '0 && pwdata[0]) |=> output_on && iso_relay)
    else $error("reset command left output off");
  iso_rd_a: assert property (acc_rd(REG_ISOL) |-> prdata == {31'h0, iso_relay})
    else $error("isolation read wrong");
  pol_hold_a: assert property (acc_wr(REG_POL) ##0 iso_relay |=> $stable(pol_inverted))
    else $error("polarity changed with relay closed");
  pol_rd_a: assert property (acc_rd(REG_POL) |-> prdata == {31'h0, pol_inverted})
    else $error("polarity read wrong");
  aux_rd_a: assert property (acc_rd(REG_AUX) |->
    prdata == {30'h0, aux_rail_high_enable, aux_rail_low_enable})
    else $error("aux read wrong");
  sense_wr_a: assert property (acc_wr(REG_SENSE) ##0 pwdata == 32'h1 |=> rear_sense_connector)
    else $error("remote sense not routed");
  local_rd_a: assert property (acc_rd(REG_LOCAL) |-> prdata == {31'h0, local_mode})
    else $error("local read wrong");
endmodule
bind oscmd_handler oscmd_chk #(.DEPTH(DEPTH), .AW(AW)) chk_i (.mclk, .nrst, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .output_on, .iso_relay, .pol_inverted,
  .aux_rail_low_enable, .aux_rail_high_enable, .rear_sense_connector, .local_mode);

// *** oscmd_err_mem.sv ***
// Small storage array holding the error queue entries
`timescale 1ns/1ps
module oscmd_err_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 10,
  parameter int AW = 4
) (
  input wire logic clk, // System clock
  input wire logic ce, // Clock enable
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] waddr, // Write slot
  input wire logic [WIDTH-1:0] wdata, // Entry to store
  input wire logic [AW-1:0] raddr, // Read slot
  output logic [WIDTH-1:0] rdata // Registered read entry
);
  logic [WIDTH-1:0] mem [DEPTH]; // Entry array

  // Write port and registered read port; read follows address one cycle late
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// *** oscmd_handler.sv ***
// Output and system command handler with an APB register port
`timescale 1ns/1ps
module oscmd_handler
  import oscmd_pkg::*;
#(
  parameter int DEPTH = ERR_DEPTH, // Error queue entries
  parameter int AW = 4 // Queue pointer width
) (
  input wire logic mclk, // System clock, 10 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high writes
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error answer
  input wire logic trip_in, // Protection trip pin, asynchronous
  input wire logic ext_err_valid, // Error event pulse from other logic
  input wire logic [15:0] ext_err_code, // Its error number
  input wire logic [7:0] ext_err_len, // Its text length
  output logic output_on, // Output at programmed value
  output logic iso_relay, // Isolation relay control, high closed
  output logic pol_inverted, // Polarity relay, high inverted
  output logic aux_rail_low_enable, // 5 V auxiliary rail on
  output logic aux_rail_high_enable, // 15 V auxiliary rail on
  output logic rear_sense_connector, // Sense taken from rear connector
  output logic local_mode, // High local, low remote operation
  output logic auto_ip_enable // Auto IP in primary configuration
);
  // Reset release synchroniser
  logic rst_s1_reg; // First stage
  logic rst_n; // Released reset copy
  // Trip pin synchroniser
  logic trip_s1_reg; // First stage, read only by second
  logic trip_asserted; // Synchronised trip level
  // Bus slave
  oscmd_bus_st_t st_reg; // Slave state
  oscmd_bus_st_t st_next; // Its next value
  logic access; // Access phase present
  logic done; // Transfer completes this edge
  logic wr_done; // Write completes
  logic rd_done; // Read completes
  logic [31:0] rd_mux; // Read data selected
  logic [15:0] acc_code; // Error raised by this access
  logic [7:0] acc_len; // Its text length
  logic acc_bad; // Access refused on the bus
  logic apply; // Write accepted and applied
  // Control state
  logic sense_def_reg; // Stored power-on sense source
  // Error queue
  logic [AW-1:0] head_reg; // Oldest entry slot
  logic [AW-1:0] tail_reg; // Next free slot
  logic [AW-1:0] count_reg; // Entries held
  logic ext_pend_reg; // External error waiting for the port
  logic [ERR_ENTRY_W-1:0] ext_entry_reg; // Waiting entry
  logic [ERR_ENTRY_W-1:0] q_wdata; // Entry to queue
  logic [ERR_ENTRY_W-1:0] q_rdata; // Oldest entry
  logic q_push; // Push request
  logic q_full; // Queue at capacity
  logic q_we; // Push actually stored
  logic q_pop; // Oldest entry removed
  logic q_clr; // Clear-status command
  logic bus_push; // Access error takes the port
  logic [7:0] ext_len_cut; // External text length, clamped

  // Known register offsets
  function automatic logic reg_known(input logic [7:0] a);
    case (a)
      REG_OUT_STATE, REG_SENSE, REG_SENSE_DEF, REG_TRIP, REG_AUX, REG_ISOL,
      REG_POL, REG_LOCAL, REG_AUTOIP, REG_ERR, REG_CMD, REG_ERR_CNT: begin
        reg_known = 1'b1;
      end
      default: begin
        reg_known = 1'b0;
      end
    endcase
  endfunction

  // Registers that take a write
  function automatic logic reg_writable(input logic [7:0] a);
    case (a)
      REG_TRIP, REG_ERR, REG_ERR_CNT: begin
        reg_writable = 1'b0;
      end
      default: begin
        reg_writable = reg_known(a);
      end
    endcase
  endfunction

  // Queue slot advance with wrap at the queue depth
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      ptr_next = '0;
    end else begin
      ptr_next = p + 1'b1;
    end
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Trip pin synchroniser; only the second stage is looked at
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trip_s1_reg <= 1'b0;
      trip_asserted <= 1'b0;
    end else if (ce) begin
      trip_s1_reg <= trip_in;
      trip_asserted <= trip_s1_reg;
    end
  end

  // Transfer phases: answer one cycle after the access phase starts
  assign access = psel && penable;
  assign done = access && (st_reg == OSCMD_ANSWER);
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;

  // Slave state: idle, then one answer cycle with pready high
  always_comb begin
    case (st_reg)
      OSCMD_IDLE: begin
        st_next = access ? OSCMD_ANSWER : OSCMD_IDLE;
      end
      OSCMD_ANSWER: begin
        st_next = OSCMD_IDLE;
      end
      default: begin
        st_next = OSCMD_IDLE;
      end
    endcase
  end

  // Classify the access; stable through the whole access phase
  always_comb begin
    acc_code = ERR_NONE;
    acc_len = '0;
    acc_bad = 1'b0;
    if (!reg_known(paddr) || (pwrite && !reg_writable(paddr))) begin
      // Unmapped address or write to a read-only register
      acc_code = ERR_UNDEF_HDR;
      acc_len = LEN_UNDEF_HDR;
      acc_bad = 1'b1;
    end else if (pwrite) begin
      case (paddr)
        REG_AUX, REG_CMD: begin
          // Two-bit fields, other bits must be zero
          if (pwdata[31:2] != '0) begin
            acc_code = ERR_ILLEGAL;
            acc_len = LEN_ILLEGAL;
          end
        end
        REG_POL: begin
          if (pwdata[31:1] != '0) begin
            acc_code = ERR_ILLEGAL;
            acc_len = LEN_ILLEGAL;
          end else if (iso_relay) begin
            // Relay still closed: switching polarity under load is refused
            acc_code = ERR_CONFLICT;
            acc_len = LEN_CONFLICT;
          end
        end
        default: begin
          // Boolean registers take only zero or one
          if (pwdata[31:1] != '0) begin
            acc_code = ERR_ILLEGAL;
            acc_len = LEN_ILLEGAL;
          end
        end
      endcase
    end
  end

  assign apply = wr_done && (acc_code == ERR_NONE);

  // Read data selection
  always_comb begin
    rd_mux = '0;
    case (paddr)
      REG_OUT_STATE: rd_mux[0] = output_on;
      REG_SENSE: rd_mux[0] = rear_sense_connector;
      REG_SENSE_DEF: rd_mux[0] = sense_def_reg;
      REG_TRIP: rd_mux[0] = trip_asserted;
      REG_AUX: begin
        rd_mux[AUX_LOW_BIT] = aux_rail_low_enable;
        rd_mux[AUX_HIGH_BIT] = aux_rail_high_enable;
      end
      REG_ISOL: rd_mux[0] = iso_relay;
      REG_POL: rd_mux[0] = pol_inverted;
      REG_LOCAL: rd_mux[0] = local_mode;
      REG_AUTOIP: rd_mux[0] = auto_ip_enable;
      REG_ERR: begin
        // Empty queue answers code zero with no text
        if (count_reg != '0) begin
          rd_mux[ERR_ENTRY_W-1:0] = q_rdata;
        end
      end
      REG_ERR_CNT: rd_mux[AW-1:0] = count_reg;
      default: rd_mux = '0;
    endcase
  end

  // Bus answer registers: data and error captured as pready rises
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= OSCMD_IDLE;
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
      pready <= (st_next == OSCMD_ANSWER);
      if (st_reg == OSCMD_IDLE && access) begin
        prdata <= pwrite ? '0 : rd_mux;
        pslverr <= acc_bad;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Output enable and isolation relay; output on also closes the relay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_on <= OUT_POR;
      iso_relay <= ISO_POR;
    end else if (ce && apply) begin
      if (paddr == REG_OUT_STATE) begin
        output_on <= pwdata[0];
        iso_relay <= pwdata[0];
      end else if (paddr == REG_ISOL) begin
        iso_relay <= pwdata[0];
      end else if (paddr == REG_CMD && pwdata[CMD_RST_BIT]) begin
        // Reset command brings the output on, relay closed with it
        output_on <= 1'b1;
        iso_relay <= 1'b1;
      end
    end
  end

  // Polarity relay; only reached when the relay was open
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pol_inverted <= POL_NORM;
    end else if (ce && apply && paddr == REG_POL) begin
      pol_inverted <= pwdata[0];
    end
  end

  // Auxiliary rails on the analog connector
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aux_rail_low_enable <= 1'b0;
      aux_rail_high_enable <= 1'b0;
    end else if (ce && apply && paddr == REG_AUX) begin
      aux_rail_low_enable <= pwdata[AUX_LOW_BIT];
      aux_rail_high_enable <= pwdata[AUX_HIGH_BIT];
    end
  end

  // Sense source: active setting and stored power-on default
  // The active copy starts from the same constant the default holds
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rear_sense_connector <= SENSE_POR;
      sense_def_reg <= SENSE_POR;
    end else if (ce && apply) begin
      if (paddr == REG_SENSE) begin
        rear_sense_connector <= pwdata[0];
      end
      if (paddr == REG_SENSE_DEF) begin
        sense_def_reg <= pwdata[0];
      end
    end
  end

  // Local or remote operation, and Auto IP of the primary setup
  // Only the primary configuration lives here; the secondary is untouched
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      local_mode <= LOCAL_POR;
      auto_ip_enable <= AUTOIP_POR;
    end else if (ce && apply) begin
      if (paddr == REG_LOCAL) begin
        local_mode <= pwdata[0];
      end
      if (paddr == REG_AUTOIP) begin
        auto_ip_enable <= pwdata[0];
      end
    end
  end

  // Error queue control
  assign bus_push = done && (acc_code != ERR_NONE);
  assign q_push = bus_push || ext_pend_reg;
  assign q_wdata = bus_push ? {acc_len, acc_code} : ext_entry_reg;
  assign q_full = (count_reg == AW'(DEPTH));
  assign q_we = q_push && (!q_full || q_clr);
  assign q_pop = rd_done && (paddr == REG_ERR) && (count_reg != '0) && !q_clr;
  assign q_clr = apply && (paddr == REG_CMD) && pwdata[CMD_CLS_BIT];

  // Clamp external text so the whole reply fits its limit
  assign ext_len_cut = (ext_err_len > TEXT_MAX) ? TEXT_MAX : ext_err_len;

  // One-deep hold for external errors while an access error owns the port
  // A new event in the cycle the hold drains is kept, not lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_pend_reg <= 1'b0;
      ext_entry_reg <= '0;
    end else if (ce) begin
      if (ext_err_valid) begin
        ext_pend_reg <= 1'b1;
        ext_entry_reg <= {ext_len_cut, ext_err_code};
      end else if (!bus_push) begin
        ext_pend_reg <= 1'b0;
      end
    end
  end

  // Pointers and fill level; clear first, then a push lands in slot zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      head_reg <= '0;
      tail_reg <= '0;
      count_reg <= '0;
    end else if (ce) begin
      if (q_clr) begin
        head_reg <= '0;
        tail_reg <= q_we ? AW'(1) : '0;
        count_reg <= q_we ? AW'(1) : '0;
      end else begin
        if (q_we) begin
          tail_reg <= ptr_next(tail_reg);
        end
        if (q_pop) begin
          head_reg <= ptr_next(head_reg);
        end
        if (q_we && !q_pop) begin
          count_reg <= count_reg + 1'b1;
        end else if (q_pop && !q_we) begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

  // Entry storage; read data registered and follows the head slot
  oscmd_err_mem #(
    .WIDTH(ERR_ENTRY_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_err_mem (
    .clk(mclk),
    .ce(ce),
    .we(q_we),
    .waddr(q_clr ? '0 : tail_reg),
    .wdata(q_wdata),
    .raddr(head_reg),
    .rdata(q_rdata)
  );
endmodule

// *** oscmd_host.sv ***
// Bus master model standing in for the remote host
`timescale 1ns/1ps
module oscmd_host (
  input wire logic mclk, // Clock
  output logic psel = 1'b0, // Select
  output logic penable = 1'b0, // Access phase
  output logic pwrite = 1'b0, // Direction
  output logic [7:0] paddr = 8'h00, // Address
  output logic [31:0] pwdata = 32'h0, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr // Error
);
  // Setup, access, bounded wait for ready, then release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data must not look valid
  endtask
endmodule

// *** oscmd_pkg.sv ***
// Constants, register map and error codes of the output and system command handler
package oscmd_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] REG_OUT_STATE = 8'h00;
  localparam logic [7:0] REG_SENSE = 8'h04;
  localparam logic [7:0] REG_SENSE_DEF = 8'h08;
  localparam logic [7:0] REG_TRIP = 8'h0c;
  localparam logic [7:0] REG_AUX = 8'h10;
  localparam logic [7:0] REG_ISOL = 8'h14;
  localparam logic [7:0] REG_POL = 8'h18;
  localparam logic [7:0] REG_LOCAL = 8'h1c;
  localparam logic [7:0] REG_AUTOIP = 8'h20;
  localparam logic [7:0] REG_ERR = 8'h24;
  localparam logic [7:0] REG_CMD = 8'h28;
  localparam logic [7:0] REG_ERR_CNT = 8'h2c;
  // Field positions
  localparam int AUX_LOW_BIT = 0;
  localparam int AUX_HIGH_BIT = 1;
  localparam int CMD_RST_BIT = 0;
  localparam int CMD_CLS_BIT = 1;
  localparam int ERR_LEN_LSB = 16;
  // Power-on values
  localparam logic OUT_POR = 1'b0;
  localparam logic ISO_POR = 1'b0;
  localparam logic POL_NORM = 1'b0;
  localparam logic SENSE_LOCAL = 1'b0;
  localparam logic SENSE_POR = 1'b0;
  localparam logic LOCAL_POR = 1'b1;
  localparam logic AUTOIP_POR = 1'b0;
  // Error queue entry: signed code plus text length
  localparam int ERR_CODE_W = 16;
  localparam int ERR_LEN_W = 8;
  localparam int ERR_ENTRY_W = ERR_CODE_W + ERR_LEN_W;
  localparam int ERR_DEPTH = 10;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_UNDEF_HDR = 16'hff8f;
  localparam logic [15:0] ERR_CONFLICT = 16'hff23;
  localparam logic [15:0] ERR_ILLEGAL = 16'hff20;
  localparam logic [7:0] LEN_UNDEF_HDR = 8'h10;
  localparam logic [7:0] LEN_CONFLICT = 8'h11;
  localparam logic [7:0] LEN_ILLEGAL = 8'h17;
  // Reply budget: sign, five digits, comma and two quotes
  localparam logic [7:0] REPLY_MAX = 8'hff;
  localparam logic [7:0] REPLY_OVERHEAD = 8'h09;
  localparam logic [7:0] TEXT_MAX = REPLY_MAX - REPLY_OVERHEAD;
  // Bus slave state
  typedef enum logic [0:0] {
    OSCMD_IDLE = 1'b0,
    OSCMD_ANSWER = 1'b1
  } oscmd_bus_st_t;
endpackage

// *** test_output_and_system_command_handler.sv ***
// Self-checking bench for the output and system command handler
`timescale 1ns/1ps
module test_output_and_system_command_handler;
  import oscmd_pkg::*;
  logic mclk = 1'b0; // Clock
  logic nrst = 1'b0; // Reset, active low
  logic ce = 1'b1; // Enable, on except for a short low stretch in the error queue test
  logic trip_in = 1'b0; // Trip pin
  logic ext_err_valid = 1'b0; // Error pulse
  logic [15:0] ext_err_code = 16'h0000; // Error number
  logic [7:0] ext_err_len = 8'h00; // Text length
  logic psel, penable, pwrite, pready, pslverr; // APB control
  logic [7:0] paddr; // APB address
  logic [31:0] pwdata, prdata; // APB data
  logic output_on, iso_relay, pol_inverted, local_mode, auto_ip_enable; // Controls
  logic aux_rail_low_enable, aux_rail_high_enable, rear_sense_connector; // Rails, sense
  int num_errors = 0; // Mismatches
  int total_checks = 0; // Comparisons
  always #50 mclk = ~mclk; // 10 MHz
  oscmd_host host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  oscmd_handler uut (.mclk, .nrst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trip_in, .ext_err_valid, .ext_err_code, .ext_err_len, .output_on,
    .iso_relay, .pol_inverted, .aux_rail_low_enable, .aux_rail_high_enable,
    .rear_sense_connector, .local_mode, .auto_ip_enable);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bit_chk(input string what, input logic seen, input logic exp);
    chk(what, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One transfer; a missing answer ends the run
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    logic ok;
    host.xfer(w, a, d, q, e, ok);
    if (!ok) begin
      num_errors++;
      $display("BAD pready expected 1 seen 0");
      give_verdict();
    end
  endtask
  // Write, check the error answer, settle outputs
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    logic [31:0] q;
    logic e;
    acc(1'b1, a, d, q, e);
    bit_chk($sformatf("pslverr %h", a), e, err);
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    acc(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), q, exp);
  endtask
  task automatic t_reset();
    bit_chk("output_on", output_on, OUT_POR);
    bit_chk("local_mode", local_mode, LOCAL_POR);
    bit_chk("rear_sense", rear_sense_connector, SENSE_LOCAL);
    rd(REG_SENSE_DEF, {31'h0, SENSE_POR});
    $display("reset test done");
  endtask
  task automatic t_output();
    wr(REG_OUT_STATE, 32'h1, 1'b0);
    bit_chk("output_on", output_on, 1'b1);
    bit_chk("iso_relay", iso_relay, 1'b1);
    rd(REG_OUT_STATE, 32'h1);
    wr(REG_OUT_STATE, 32'h0, 1'b0);
    bit_chk("output_on", output_on, 1'b0);
    bit_chk("iso_relay", iso_relay, 1'b0);
    rd(REG_OUT_STATE, 32'h0);
    wr(REG_CMD, 32'h1 << CMD_RST_BIT, 1'b0);
    bit_chk("output_on", output_on, 1'b1);
    $display("output test done");
  endtask
  task automatic t_relays();
    wr(REG_ISOL, 32'h1, 1'b0);
    rd(REG_ISOL, 32'h1);
    wr(REG_POL, 32'h1, 1'b0); // Refused while closed
    bit_chk("pol", pol_inverted, POL_NORM);
    wr(REG_ISOL, 32'h0, 1'b0); // Relay opened first
    bit_chk("iso_relay", iso_relay, 1'b0);
    wr(REG_POL, 32'h1, 1'b0);
    bit_chk("pol", pol_inverted, 1'b1);
    rd(REG_POL, 32'h1);
    wr(REG_POL, 32'h0, 1'b0);
    rd(REG_POL, 32'h0);
    $display("relay test done");
  endtask
  task automatic t_sense();
    wr(REG_SENSE, 32'h1, 1'b0);
    bit_chk("rear_sense", rear_sense_connector, 1'b1);
    rd(REG_SENSE, 32'h1);
    wr(REG_SENSE_DEF, 32'h1, 1'b0);
    wr(REG_SENSE, 32'h0, 1'b0);
    rd(REG_SENSE_DEF, 32'h1);
    rd(REG_SENSE, 32'h0);
    $display("sense test done");
  endtask
  task automatic t_misc();
    for (int i = 0; i < 4; i++) begin
      wr(REG_AUX, 32'(i), 1'b0);
      bit_chk("aux_lo", aux_rail_low_enable, i[0]);
      bit_chk("aux_hi", aux_rail_high_enable, i[1]);
      rd(REG_AUX, 32'(i));
      wr(REG_LOCAL, 32'(i & 1), 1'b0);
      bit_chk("local", local_mode, i[0]);
      rd(REG_LOCAL, 32'(i & 1));
      wr(REG_AUTOIP, 32'(i >> 1), 1'b0);
      bit_chk("auto_ip", auto_ip_enable, i[1]);
      rd(REG_AUTOIP, 32'(i >> 1));
    end
    @(posedge mclk);
    trip_in <= 1'b1;
    repeat (4) @(posedge mclk); // Pin passes a two-flop synchroniser
    rd(REG_TRIP, 32'h1);
    trip_in <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(REG_TRIP, 32'h0);
    $display("misc test done");
  endtask
  task automatic t_errq();
    wr(REG_CMD, 32'h2, 1'b0); // Drop leftovers
    for (int i = 1; i <= 12; i++) begin
      @(posedge mclk);
      ext_err_valid <= 1'b1;
      ext_err_code <= 16'(i);
      ext_err_len <= (i == 1) ? 8'hff : 8'h05;
      @(posedge mclk);
      ext_err_valid <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    rd(REG_ERR_CNT, 32'(ERR_DEPTH));
    rd(REG_ERR, {8'h0, TEXT_MAX, 16'h0001});
    for (int i = 2; i <= 10; i++) begin
      rd(REG_ERR, {16'h0005, 16'(i)});
    end
    rd(REG_ERR, 32'h0); // Late entries gone
    wr(8'h30, 32'h0, 1'b1); // Unmapped
    rd(REG_ERR, {8'h0, LEN_UNDEF_HDR, ERR_UNDEF_HDR});
    wr(REG_AUX, 32'h4, 1'b0); // Bit beyond the field, write refused and queued as illegal
    bit_chk("aux_hi", aux_rail_high_enable, 1'b1);
    rd(REG_ERR, {8'h0, LEN_ILLEGAL, ERR_ILLEGAL});
    wr(REG_TRIP, 32'h1, 1'b1); // Read-only
    rd(REG_ERR_CNT, 32'h1);
    wr(REG_CMD, 32'h1 << CMD_CLS_BIT, 1'b0);
    rd(REG_ERR_CNT, 32'h0);
    // Clock enable low: an error pulse in that time must not be taken
    @(posedge mclk);
    ce <= 1'b0;
    ext_err_valid <= 1'b1;
    ext_err_code <= 16'h0001;
    @(posedge mclk);
    ext_err_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    rd(REG_ERR_CNT, 32'h0);
    $display("error queue test done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_output();
    t_relays();
    t_sense();
    t_misc();
    t_errq();
    give_verdict();
  end
endmodule
